//--- pkg/gcr_params.svh
// Constants of the global configuration register group.
`ifndef GCR_PARAMS_SVH
`define GCR_PARAMS_SVH

// Configuration register indices.
`define GCR_IDX_LDN 8'h07
`define GCR_IDX_ID_HI 8'h20
`define GCR_IDX_ID_LO 8'h21
`define GCR_IDX_PWR 8'h22
`define GCR_IDX_IPD 8'h23
`define GCR_IDX_OPT24 8'h24
`define GCR_IDX_FLOAT 8'h25
`define GCR_IDX_OPT26 8'h26

// Entry ports, the data port sits one above the index port.
`define GCR_PORT_LO 16'h002e
`define GCR_PORT_HI 16'h004e
`define GCR_PORT_DATA_OFS 16'h0001
`define GCR_ENTRY_KEY 8'h87
`define GCR_EXIT_KEY 8'haa

// Reset values; strap-loaded bits are zero here and patched later.
`define GCR_RST_LDN 8'h00
`define GCR_RST_PWR 8'hff
`define GCR_RST_IPD 8'h00
`define GCR_RST_OPT24 8'h40
`define GCR_RST_FLOAT 8'h00
`define GCR_RST_OPT26 8'h00
`define GCR_RST_BYTE 8'h00
`define GCR_RST_NIB 4'h0

// Writable bit masks; other bits keep their reset or strap-loaded value.
`define GCR_WMASK_PWR 8'h79
`define GCR_WMASK_IPD 8'h01
`define GCR_WMASK_OPT24 8'hfa
`define GCR_WMASK_FLOAT 8'h39
`define GCR_WMASK_OPT26 8'h6f

// Field positions.
`define GCR_B_HM 6
`define GCR_B_SERB 5
`define GCR_B_SERA 4
`define GCR_B_PRT 3
`define GCR_B_FDC 0
`define GCR_B_IPD 0
`define GCR_B_FAN1 7
`define GCR_B_INPUT_CLOCK_RATE_SELECT 6
`define GCR_B_AUXFAN 5
`define GCR_B_SYSFAN 4
`define GCR_B_FAN0 3
`define GCR_B_KBC 2
`define GCR_B_FLASH 1
`define GCR_B_PORTSEL 6
`define GCR_B_LOCK 5
`define GCR_B_FDIRQ 3
`define GCR_B_PRIRQ 2
`define GCR_B_SAIRQ 1
`define GCR_B_SBIRQ 0
`define GCR_B_ST_CONFIG 2

// Shared pin slots.
`define GCR_PIN_CLK 0
`define GCR_PIN_CE 1
`define GCR_PIN_DIN 2
`define GCR_PIN_DOUT 3

`endif

//--- pkg/gcr_pkg.sv
// Types of the global configuration register group.
package gcr_pkg;

   // Configuration entry sequence states.
   typedef enum logic [2:0] {
      GCR_ST_IDLE = 3'b001,
      GCR_ST_KEY1 = 3'b010,
      GCR_ST_CONFIG = 3'b100
   } gcr_cfg_state_t;

   // State of the strap catcher.
   typedef struct packed {
      logic done;
      logic load;
      logic keyboard_controller;
      logic flash;
      logic portsel;
   } gcr_strap_t;

   // State of the register group.
   typedef struct packed {
      gcr_cfg_state_t cfg_st;
      logic [7:0] index;
      logic [7:0] ldn;
      logic [7:0] pwr;
      logic [7:0] immediate_power_down_bit;
      logic [7:0] opt24;
      logic [7:0] flt;
      logic [7:0] opt26;
      logic [7:0] rdata;
      logic rvalid;
      logic [4:0] func_en;
      logic chip_pd;
      logic clk48;
      logic [3:0] fan_od;
      logic kbc_en;
      logic flash_en;
      logic [3:0] float_en;
      logic [3:0] irq_eff;
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic flash_din;
      logic fan_tach;
   } gcr_state_t;

endpackage

//--- src/gcr_strap_latch.sv
// Catches the power-on strap pins once, just after reset release.
`timescale 1ns/10ps
module gcr_strap_latch (
   input wire logic sys_clk, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic kbc_strap, // Keyboard controller enable strap.
   input wire logic flash_strap, // Flash interface enable strap.
   input wire logic portsel_strap, // Entry port select strap.
   output logic load, // One-cycle pulse carrying the caught values.
   output logic keyboard_controller, // Caught keyboard strap.
   output logic flash, // Caught flash strap.
   output logic portsel // Caught entry port strap.
);

   gcr_pkg::gcr_strap_t st_r;
   gcr_pkg::gcr_strap_t st_nxt;

   // The pins are sampled in the first cycle after release, so reset
   // itself only ever loads constants.
   always_comb begin
      st_nxt = st_r;
      st_nxt.load = 1'b0;
      if (!st_r.done) begin
         st_nxt.done = 1'b1;
         st_nxt.load = 1'b1;
         st_nxt.keyboard_controller = kbc_strap;
         st_nxt.flash = flash_strap;
         st_nxt.portsel = portsel_strap;
      end
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign load = st_r.load;
   assign keyboard_controller = st_r.keyboard_controller;
   assign flash = st_r.flash;
   assign portsel = st_r.portsel;

endmodule

//--- src/gcr_top.sv
// Global configuration register group behind the config index/data ports.
`timescale 1ns/10ps
`include "gcr_params.svh"
module gcr_top #(
   parameter logic [7:0] CHIP_ID_HIGH = 8'h5a, // Arbitrary value.
   parameter logic [3:0] CHIP_ID_LOW_UPPER = 4'h3, // Arbitrary value.
   parameter logic [3:0] SILICON_REV = 4'h1 // Arbitrary value.
) (
   input wire logic sys_clk, // System clock, 100 MHz.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic [15:0] io_addr, // Host I/O address.
   input wire logic io_wr, // Host I/O write strobe, one cycle.
   input wire logic io_rd, // Host I/O read strobe, one cycle.
   input wire logic [7:0] io_wdata, // Host I/O write data.
   output logic [7:0] io_rdata, // Read data.
   output logic io_rvalid, // Read data valid, one cycle.
   input wire logic kbc_strap, // Keyboard enable strap level.
   input wire logic flash_strap, // Flash interface enable strap level.
   input wire logic portsel_strap, // Entry port select strap level.
   output logic [7:0] ldn_sel, // Selected logical device number.
   output logic config_active, // Configuration mode entered.
   output logic hm_en, // Hardware monitor powered and active.
   output logic serb_en, // Second serial port powered and active.
   output logic sera_en, // First serial port powered and active.
   output logic prt_en, // Parallel port powered and active.
   output logic fdc_en, // Floppy controller powered and active.
   output logic chip_power_down, // Whole chip powered down.
   output logic clk_is_48m, // Input clock treated as 48 MHz.
   output logic fan1_open_drain, // Processor fan drive 1 open-drain.
   output logic aux_fan_open_drain, // Auxiliary fan drive open-drain.
   output logic sys_fan_open_drain, // System fan drive open-drain.
   output logic fan0_open_drain, // Processor fan drive 0 open-drain.
   output logic kbc_en, // Keyboard controller enabled.
   output logic flash_en, // Flash interface enabled.
   output logic serb_float, // Float second serial port pins.
   output logic sera_float, // Float first serial port pins.
   output logic prt_float, // Float parallel port pins.
   output logic fdc_float, // Float floppy controller pins.
   input wire logic fdc_dor_irq_bit, // Floppy output register bit 3.
   input wire logic prt_dcr_irq_bit, // Parallel control register bit 4.
   input wire logic sera_hcr_irq_bit, // First serial handshake bit 3.
   input wire logic serb_hcr_irq_bit, // Second serial handshake bit 3.
   output logic fdc_irq_sel, // Floppy bit effective for IRQ select.
   output logic prt_irq_sel, // Parallel bit effective for IRQ select.
   output logic sera_irq_sel, // First serial bit effective.
   output logic serb_irq_sel, // Second serial bit effective.
   input wire logic flash_clk, // Flash clock from the flash engine.
   input wire logic flash_chip_enable, // Flash chip enable from engine.
   input wire logic flash_dout, // Flash data out from engine.
   output logic flash_din, // Flash data in toward the engine.
   input wire logic gpio23_out, // General I/O 23 output level.
   input wire logic gpio23_oe, // General I/O 23 output enable.
   input wire logic gpio22_out, // General I/O 22 output level.
   input wire logic gpio22_oe, // General I/O 22 output enable.
   input wire logic beep, // Beep output level.
   output logic fan_tach, // Auxiliary fan tachometer input level.
   input wire logic [3:0] shared_pin_in, // Shared pin input levels.
   output logic [3:0] shared_pin_out, // Shared pin output levels.
   output logic [3:0] shared_pin_oe // Shared pin enables, high drives.
);

   gcr_pkg::gcr_state_t s_r;
   gcr_pkg::gcr_state_t s_nxt;
   logic strap_load;
   logic strap_kbc;
   logic strap_flash;
   logic strap_portsel;

   // Index port for the current entry port select.
   function automatic logic [15:0] index_port(input logic sel);
      index_port = sel ? `GCR_PORT_HI : `GCR_PORT_LO;
   endfunction

   // Masked write: only writable bits take the new value.
   function automatic logic [7:0] mwrite(input logic [7:0] old,
                                         input logic [7:0] val,
                                         input logic [7:0] mask);
      mwrite = (old & ~mask) | (val & mask);
   endfunction

   // Readback of one configuration register.
   function automatic logic [7:0] reg_read(
         input gcr_pkg::gcr_state_t st);
      case (st.index)
         `GCR_IDX_LDN: reg_read = st.ldn;
         `GCR_IDX_ID_HI: reg_read = CHIP_ID_HIGH;
         `GCR_IDX_ID_LO: reg_read = {CHIP_ID_LOW_UPPER,
                                     SILICON_REV};
         `GCR_IDX_PWR: reg_read = st.pwr;
         `GCR_IDX_IPD: reg_read = st.immediate_power_down_bit;
         `GCR_IDX_OPT24: reg_read = st.opt24;
         `GCR_IDX_FLOAT: reg_read = st.flt;
         `GCR_IDX_OPT26: reg_read = st.opt26;
         default: reg_read = `GCR_RST_BYTE;
      endcase
   endfunction

   // Strap pins are caught once after reset release.
   gcr_strap_latch u_strap (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .kbc_strap(kbc_strap),
      .flash_strap(flash_strap),
      .portsel_strap(portsel_strap),
      .load(strap_load),
      .keyboard_controller(strap_kbc),
      .flash(strap_flash),
      .portsel(strap_portsel)
   );

   // Next-state logic: entry sequence, register access, derived outputs.
   always_comb begin
      logic [15:0] idx_port;
      logic [15:0] dat_port;
      logic hit_idx;
      logic hit_dat;
      logic in_cfg;
      logic locked;
      idx_port = index_port(s_r.opt26[`GCR_B_PORTSEL]);
      dat_port = idx_port + `GCR_PORT_DATA_OFS;
      hit_idx = (io_addr == idx_port);
      hit_dat = (io_addr == dat_port);
      in_cfg = (s_r.cfg_st == gcr_pkg::GCR_ST_CONFIG);
      // Register 26 itself stays open, otherwise the lock could never
      // be released again by software.
      locked = s_r.opt26[`GCR_B_LOCK] &&
               (s_r.index != `GCR_IDX_OPT26);
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;

      // Writes to the index port drive the entry sequence.
      if (io_wr && hit_idx) begin
         case (s_r.cfg_st)
            gcr_pkg::GCR_ST_IDLE: begin
               if (io_wdata == `GCR_ENTRY_KEY) begin
                  s_nxt.cfg_st = gcr_pkg::GCR_ST_KEY1;
               end
            end
            gcr_pkg::GCR_ST_KEY1: begin
               if (io_wdata == `GCR_ENTRY_KEY) begin
                  s_nxt.cfg_st = gcr_pkg::GCR_ST_CONFIG;
               end else begin
                  s_nxt.cfg_st = gcr_pkg::GCR_ST_IDLE;
               end
            end
            gcr_pkg::GCR_ST_CONFIG: begin
               if (io_wdata == `GCR_EXIT_KEY) begin
                  s_nxt.cfg_st = gcr_pkg::GCR_ST_IDLE;
               end else begin
                  s_nxt.index = io_wdata;
               end
            end
            default: begin
               s_nxt.cfg_st = gcr_pkg::GCR_ST_IDLE;
            end
         endcase
      end

      // Data port writes update the selected register.
      if (io_wr && hit_dat && in_cfg && !locked) begin
         case (s_r.index)
            `GCR_IDX_LDN: begin
               s_nxt.ldn = io_wdata;
            end
            `GCR_IDX_PWR: begin
               s_nxt.pwr = mwrite(s_r.pwr, io_wdata,
                                  `GCR_WMASK_PWR);
            end
            `GCR_IDX_IPD: begin
               s_nxt.immediate_power_down_bit = mwrite(s_r.immediate_power_down_bit, io_wdata,
                                  `GCR_WMASK_IPD);
            end
            `GCR_IDX_OPT24: begin
               // The keyboard bit is outside the mask and keeps its strap.
               s_nxt.opt24 = mwrite(s_r.opt24, io_wdata,
                                    `GCR_WMASK_OPT24);
            end
            `GCR_IDX_FLOAT: begin
               s_nxt.flt = mwrite(s_r.flt, io_wdata,
                                  `GCR_WMASK_FLOAT);
            end
            `GCR_IDX_OPT26: begin
               s_nxt.opt26 = mwrite(s_r.opt26, io_wdata,
                                    `GCR_WMASK_OPT26);
            end
            default: begin
               // Identification bytes and unmapped indices ignore writes.
               s_nxt.ldn = s_r.ldn;
            end
         endcase
      end

      // Reads answer one cycle later, only while configuration is open.
      if (io_rd && in_cfg && hit_idx) begin
         s_nxt.rdata = s_r.index;
         s_nxt.rvalid = 1'b1;
      end else if (io_rd && in_cfg && hit_dat) begin
         s_nxt.rdata = locked ? `GCR_RST_BYTE : reg_read(s_r);
         s_nxt.rvalid = 1'b1;
      end

      // Strap values land in their register bits once after reset.
      if (strap_load) begin
         s_nxt.opt24[`GCR_B_KBC] = strap_kbc;
         s_nxt.opt24[`GCR_B_FLASH] = strap_flash;
         s_nxt.opt26[`GCR_B_PORTSEL] = strap_portsel;
      end

      // Function enables follow the gate bits and the global power-down.
      s_nxt.chip_pd = s_nxt.immediate_power_down_bit[`GCR_B_IPD];
      s_nxt.func_en[4] = s_nxt.pwr[`GCR_B_HM] && !s_nxt.chip_pd;
      s_nxt.func_en[3] = s_nxt.pwr[`GCR_B_SERB] && !s_nxt.chip_pd;
      s_nxt.func_en[2] = s_nxt.pwr[`GCR_B_SERA] && !s_nxt.chip_pd;
      s_nxt.func_en[1] = s_nxt.pwr[`GCR_B_PRT] && !s_nxt.chip_pd;
      s_nxt.func_en[0] = s_nxt.pwr[`GCR_B_FDC] && !s_nxt.chip_pd;

      // Clock rate and fan drive types; two fan bits have inverted sense.
      s_nxt.clk48 = s_nxt.opt24[`GCR_B_INPUT_CLOCK_RATE_SELECT];
      s_nxt.fan_od[3] = s_nxt.opt24[`GCR_B_FAN1];
      s_nxt.fan_od[2] = s_nxt.opt24[`GCR_B_AUXFAN];
      s_nxt.fan_od[1] = !s_nxt.opt24[`GCR_B_SYSFAN];
      s_nxt.fan_od[0] = !s_nxt.opt24[`GCR_B_FAN0];
      s_nxt.kbc_en = s_nxt.opt24[`GCR_B_KBC];
      s_nxt.flash_en = s_nxt.opt24[`GCR_B_FLASH];

      // Interface float controls.
      s_nxt.float_en[3] = s_nxt.flt[`GCR_B_SERB];
      s_nxt.float_en[2] = s_nxt.flt[`GCR_B_SERA];
      s_nxt.float_en[1] = s_nxt.flt[`GCR_B_PRT];
      s_nxt.float_en[0] = s_nxt.flt[`GCR_B_FDC];

      // Legacy IRQ selection bits pass only while not overridden.
      s_nxt.irq_eff[3] = fdc_dor_irq_bit &&
                         !s_nxt.opt26[`GCR_B_FDIRQ];
      s_nxt.irq_eff[2] = prt_dcr_irq_bit &&
                         !s_nxt.opt26[`GCR_B_PRIRQ];
      s_nxt.irq_eff[1] = sera_hcr_irq_bit &&
                         !s_nxt.opt26[`GCR_B_SAIRQ];
      s_nxt.irq_eff[0] = serb_hcr_irq_bit &&
                         !s_nxt.opt26[`GCR_B_SBIRQ];

      // Shared pins follow the flash enable; the mux adds one cycle of
      // latency, which the slow flash clock tolerates.
      if (s_nxt.flash_en) begin
         s_nxt.pin_out[`GCR_PIN_CLK] = flash_clk;
         s_nxt.pin_oe[`GCR_PIN_CLK] = 1'b1;
         s_nxt.pin_out[`GCR_PIN_CE] = flash_chip_enable;
         s_nxt.pin_oe[`GCR_PIN_CE] = 1'b1;
         s_nxt.pin_out[`GCR_PIN_DIN] = 1'b0;
         s_nxt.pin_oe[`GCR_PIN_DIN] = 1'b0;
         s_nxt.pin_out[`GCR_PIN_DOUT] = flash_dout;
         s_nxt.pin_oe[`GCR_PIN_DOUT] = 1'b1;
         s_nxt.flash_din = shared_pin_in[`GCR_PIN_DIN];
         s_nxt.fan_tach = 1'b0;
      end else begin
         s_nxt.pin_out[`GCR_PIN_CLK] = gpio23_out;
         s_nxt.pin_oe[`GCR_PIN_CLK] = gpio23_oe;
         s_nxt.pin_out[`GCR_PIN_CE] = gpio22_out;
         s_nxt.pin_oe[`GCR_PIN_CE] = gpio22_oe;
         s_nxt.pin_out[`GCR_PIN_DIN] = 1'b0;
         s_nxt.pin_oe[`GCR_PIN_DIN] = 1'b0;
         s_nxt.pin_out[`GCR_PIN_DOUT] = beep;
         s_nxt.pin_oe[`GCR_PIN_DOUT] = 1'b1;
         s_nxt.flash_din = 1'b0;
         s_nxt.fan_tach = shared_pin_in[`GCR_PIN_DIN];
      end
   end

   // State register; reset values match the documented defaults.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.cfg_st <= gcr_pkg::GCR_ST_IDLE;
         s_r.index <= `GCR_RST_BYTE;
         s_r.ldn <= `GCR_RST_LDN;
         s_r.pwr <= `GCR_RST_PWR;
         s_r.immediate_power_down_bit <= `GCR_RST_IPD;
         s_r.opt24 <= `GCR_RST_OPT24;
         s_r.flt <= `GCR_RST_FLOAT;
         s_r.opt26 <= `GCR_RST_OPT26;
         s_r.func_en <= 5'h1f;
         s_r.clk48 <= 1'b1;
         s_r.fan_od <= 4'h3;
         s_r.pin_oe <= `GCR_RST_NIB;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register.
   assign io_rdata = s_r.rdata;
   assign io_rvalid = s_r.rvalid;
   assign ldn_sel = s_r.ldn;
   assign config_active = s_r.cfg_st[`GCR_B_ST_CONFIG];
   assign hm_en = s_r.func_en[4];
   assign serb_en = s_r.func_en[3];
   assign sera_en = s_r.func_en[2];
   assign prt_en = s_r.func_en[1];
   assign fdc_en = s_r.func_en[0];
   assign chip_power_down = s_r.chip_pd;
   assign clk_is_48m = s_r.clk48;
   assign fan1_open_drain = s_r.fan_od[3];
   assign aux_fan_open_drain = s_r.fan_od[2];
   assign sys_fan_open_drain = s_r.fan_od[1];
   assign fan0_open_drain = s_r.fan_od[0];
   assign kbc_en = s_r.kbc_en;
   assign flash_en = s_r.flash_en;
   assign serb_float = s_r.float_en[3];
   assign sera_float = s_r.float_en[2];
   assign prt_float = s_r.float_en[1];
   assign fdc_float = s_r.float_en[0];
   assign fdc_irq_sel = s_r.irq_eff[3];
   assign prt_irq_sel = s_r.irq_eff[2];
   assign sera_irq_sel = s_r.irq_eff[1];
   assign serb_irq_sel = s_r.irq_eff[0];
   assign flash_din = s_r.flash_din;
   assign fan_tach = s_r.fan_tach;
   assign shared_pin_out = s_r.pin_out;
   assign shared_pin_oe = s_r.pin_oe;

endmodule

//--- verification/gcr_top_properties.sv
// Port checks of the global configuration register group.
`timescale 1ns/10ps
module gcr_checker (
   input wire logic sys_clk, // Clock.
   input wire logic rstn, // Reset, active low.
   input wire logic io_rd, // Read strobe.
   input wire logic io_rvalid, // Read answer.
   input wire logic config_active, // Config mode.
   input wire logic chip_power_down, // Chip down.
   input wire logic hm_en, // Monitor on.
   input wire logic fdc_en, // Floppy on.
   input wire logic kbc_en, // Keyboard on.
   input wire logic flash_en, // Flash on.
   input wire logic fdc_dor_irq_bit, // Floppy bit.
   input wire logic prt_dcr_irq_bit, // Parallel bit.
   input wire logic sera_hcr_irq_bit, // Serial bit.
   input wire logic fdc_irq_sel, // Floppy select.
   input wire logic prt_irq_sel, // Parallel select.
   input wire logic sera_irq_sel, // Serial select.
   input wire logic flash_dout, // Flash out.
   input wire logic [3:0] shared_pin_in, // Pin levels.
   input wire logic [3:0] shared_pin_out, // Pin drive.
   input wire logic [3:0] shared_pin_oe, // Pin enables.
   input wire logic flash_din, // Flash in.
   input wire logic fan_tach // Tach in.
);
   logic [2:0] up_r;
   logic [2:0] up_nxt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Cycles since release; strap loading settles in the first few.
   always_comb up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
   always_ff @(posedge sys_clk) up_r <= rstn ? up_nxt : 3'h0;
   AST_KBC_FIXED: assert property (up_r > 3'h3 |-> $stable(kbc_en))
      else $error("keyboard enable changed");
   AST_IPD_GATES: assert property (
      chip_power_down |-> !hm_en && !fdc_en)
      else $error("function active in power down");
   AST_FDC_IRQ: assert property (!$past(fdc_dor_irq_bit) |-> !fdc_irq_sel)
      else $error("floppy select without cause");
   AST_PRT_IRQ: assert property (!$past(prt_dcr_irq_bit) |-> !prt_irq_sel)
      else $error("parallel select without cause");
   AST_SERA_IRQ: assert property (
      !$past(sera_hcr_irq_bit) |-> !sera_irq_sel)
      else $error("serial select without cause");
   AST_RD_ANSWER: assert property (
      io_rvalid |-> $past(io_rd) && $past(config_active))
      else $error("read answer without request");
   AST_FLASH_PINS: assert property (
      up_r != 3'h0 && flash_en && $past(flash_en) |->
      shared_pin_oe == 4'hb && shared_pin_out[3] == $past(flash_dout))
      else $error("flash pins wrong");
   AST_FLASH_DIN: assert property (
      up_r != 3'h0 && flash_en && $past(flash_en) |->
      flash_din == $past(shared_pin_in[2]) && !fan_tach)
      else $error("flash data in wrong");
   AST_GPIO_PINS: assert property (
      up_r != 3'h0 && !flash_en && !$past(flash_en) |->
      shared_pin_oe[3:2] == 2'b10 && fan_tach == $past(shared_pin_in[2]))
      else $error("shared pins wrong");
   cover property (io_rvalid && config_active);
   cover property (chip_power_down);
   cover property (!flash_en ##1 flash_en);
endmodule
bind gcr_top gcr_checker u_chk (.sys_clk, .rstn, .io_rd, .io_rvalid,
   .config_active, .chip_power_down, .hm_en, .fdc_en, .kbc_en, .flash_en,
   .fdc_dor_irq_bit, .prt_dcr_irq_bit, .sera_hcr_irq_bit, .fdc_irq_sel,
   .prt_irq_sel, .sera_irq_sel, .flash_dout, .shared_pin_in,
   .shared_pin_out, .shared_pin_oe, .flash_din, .fan_tach);

//--- verification/gcr_host_model.sv
// Host side model of the configuration index and data ports.
`timescale 1ns/10ps
module gcr_host_model (
   input wire logic sys_clk, // Clock.
   input wire logic [7:0] io_rdata, // Read data.
   input wire logic io_rvalid, // Read answer.
   output logic [15:0] io_addr, // Port address.
   output logic io_wr, // Write strobe.
   output logic io_rd, // Read strobe.
   output logic [7:0] io_wdata // Write data.
);
   // Idle bus from time zero.
   initial begin
      io_addr = 16'h0000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // One request; released lines flip so stale values are never trusted.
   task cyc(input logic [15:0] a, input logic [7:0] d, input logic w,
      output logic [8:0] ans);
      @(posedge sys_clk);
      #1;
      io_addr = a;
      io_wdata = d;
      io_wr = w;
      io_rd = !w;
      @(posedge sys_clk);
      #1;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
      ans = {io_rvalid, io_rdata};
   endtask
   // Entry key sequence.
   task enter(input logic [15:0] p);
      logic [8:0] x;
      cyc(p, 8'h87, 1'b1, x);
      cyc(p, 8'h87, 1'b1, x);
   endtask
endmodule

//--- verification/gcr_top_tb.sv
// Self-checking bench of the global configuration register group.
`timescale 1ns/10ps
module gcr_top_tb;
   localparam logic [7:0] ID_HI = 8'h3c; // Arbitrary value.
   localparam logic [3:0] ID_UP = 4'h2; // Arbitrary value.
   localparam logic [3:0] REV = 4'h7; // Arbitrary value.
   logic sys_clk, rstn, io_wr, io_rd, io_rvalid, config_active;
   logic hm_en, serb_en, sera_en, prt_en, fdc_en, chip_power_down;
   logic clk_is_48m, fan1_open_drain, aux_fan_open_drain, kbc_en;
   logic sys_fan_open_drain, fan0_open_drain, flash_en, serb_float;
   logic sera_float, prt_float, fdc_float, fdc_irq_sel, prt_irq_sel;
   logic sera_irq_sel, serb_irq_sel, flash_din, fan_tach, strap;
   logic [15:0] io_addr, port;
   logic [7:0] io_wdata, io_rdata, ldn_sel, drv;
   logic [3:0] irq_in, pin_in, shared_pin_out, shared_pin_oe;
   logic [8:0] x;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc_cnt = 0;
   wire [8:0] optv = {2'b00, clk_is_48m, fan1_open_drain, aux_fan_open_drain,
      sys_fan_open_drain, fan0_open_drain, kbc_en, flash_en};
   wire [8:0] funv = {4'h0, hm_en, serb_en, sera_en, prt_en, fdc_en};
   wire [8:0] irqv = {5'h0, fdc_irq_sel, prt_irq_sel, sera_irq_sel,
      serb_irq_sel};
   wire [8:0] pinv = {fan_tach, shared_pin_out, shared_pin_oe};
   gcr_top #(.CHIP_ID_HIGH(ID_HI), .CHIP_ID_LOW_UPPER(ID_UP),
      .SILICON_REV(REV)) u_dut (.sys_clk, .rstn, .io_addr, .io_wr, .io_rd,
      .io_wdata, .io_rdata, .io_rvalid, .kbc_strap(strap),
      .flash_strap(strap), .portsel_strap(strap), .ldn_sel, .config_active,
      .hm_en, .serb_en,
      .sera_en, .prt_en, .fdc_en, .chip_power_down, .clk_is_48m,
      .fan1_open_drain, .aux_fan_open_drain, .sys_fan_open_drain,
      .fan0_open_drain, .kbc_en, .flash_en, .serb_float, .sera_float,
      .prt_float, .fdc_float, .fdc_dor_irq_bit(irq_in[3]),
      .prt_dcr_irq_bit(irq_in[2]), .sera_hcr_irq_bit(irq_in[1]),
      .serb_hcr_irq_bit(irq_in[0]), .fdc_irq_sel, .prt_irq_sel,
      .sera_irq_sel, .serb_irq_sel, .flash_clk(drv[0]),
      .flash_chip_enable(drv[1]), .flash_dout(drv[2]), .flash_din,
      .gpio23_out(drv[3]), .gpio23_oe(drv[4]), .gpio22_out(drv[5]),
      .gpio22_oe(drv[6]), .beep(drv[7]), .fan_tach,
      .shared_pin_in(pin_in), .shared_pin_out, .shared_pin_oe);
   gcr_host_model u_host (.sys_clk, .io_rdata, .io_rvalid, .io_addr,
      .io_wr, .io_rd, .io_wdata);
   // Free-running 100 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // A hang is cut short well above the expected few hundred cycles.
   always @(posedge sys_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         results();
      end
   end
   task chk(input logic [8:0] g, input logic [8:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wreg(input logic [7:0] i, input logic [7:0] v);
      logic [8:0] y;
      u_host.cyc(port, i, 1'b1, y);
      u_host.cyc(port + 16'h0001, v, 1'b1, y);
   endtask
   task rreg(input logic [7:0] i, input logic [8:0] e);
      logic [8:0] y;
      u_host.cyc(port, i, 1'b1, y);
      u_host.cyc(port + 16'h0001, 8'h00, 1'b0, y);
      chk(y, e);
   endtask
   task done(input string s);
      $display("Test %0s finished", s);
   endtask
   task results();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence; all straps are high, so entry starts at the upper port.
   initial begin
      rstn = 1'b0;
      strap = 1'b1;
      drv = 8'hda;
      irq_in = 4'h0;
      pin_in = 4'h4;
      port = 16'h004e;
      repeat (5) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(optv, 9'h04f);
      u_host.enter(16'h002e);
      u_host.cyc(16'h002f, 8'h00, 1'b0, x);
      chk({7'h0, config_active, x[8]}, 9'h000);
      u_host.enter(port);
      chk({8'h0, config_active}, 9'h001);
      rreg(8'h20, {1'b1, ID_HI});
      rreg(8'h21, {1'b1, ID_UP, REV});
      rreg(8'h22, 9'h1ff);
      rreg(8'h23, 9'h100);
      rreg(8'h24, 9'h146);
      rreg(8'h25, 9'h100);
      rreg(8'h26, 9'h140);
      rreg(8'h07, 9'h100);
      done("reset values");
      wreg(8'h20, 8'hff);
      rreg(8'h20, {1'b1, ID_HI});
      wreg(8'h21, 8'h00);
      rreg(8'h21, {1'b1, ID_UP, REV});
      wreg(8'h22, 8'h08);
      rreg(8'h22, 9'h18e);
      chk(funv, 9'h002);
      wreg(8'h22, 8'hff);
      wreg(8'h23, 8'h01);
      chk({7'h0, chip_power_down, hm_en}, 9'h002);
      rreg(8'h23, 9'h101);
      wreg(8'h23, 8'h00);
      chk(funv, 9'h01f);
      done("power");
      wreg(8'h24, 8'hff);
      rreg(8'h24, 9'h1fe);
      chk(optv, 9'h073);
      wreg(8'h24, 8'h00);
      chk(optv, 9'h00e);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(pinv, 9'h19b);
      wreg(8'h24, 8'h02);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(pinv, 9'h02b);
      done("options and pins");
      wreg(8'h25, 8'hff);
      rreg(8'h25, 9'h139);
      chk({5'h0, serb_float, sera_float, prt_float, fdc_float}, 9'h00f);
      irq_in = 4'hf;
      wreg(8'h26, 8'h4a);
      chk(irqv, 9'h005);
      wreg(8'h26, 8'h45);
      chk(irqv, 9'h00a);
      wreg(8'h26, 8'hff);
      rreg(8'h26, 9'h16f);
      rreg(8'h22, 9'h100);
      wreg(8'h07, 8'ha5);
      wreg(8'h26, 8'h40);
      rreg(8'h07, 9'h100);
      wreg(8'h07, 8'ha5);
      chk({1'b0, ldn_sel}, 9'h0a5);
      done("float, irq and lock");
      wreg(8'h26, 8'h00);
      port = 16'h002e;
      rreg(8'h26, 9'h100);
      u_host.cyc(port, 8'haa, 1'b1, x);
      u_host.cyc(port + 16'h0001, 8'h00, 1'b0, x);
      chk({7'h0, config_active, x[8]}, 9'h000);
      done("entry port and exit");
      // Second reset with all straps low; entry must now use the low port.
      strap = 1'b0;
      rstn = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(optv, 9'h04c);
      u_host.enter(port);
      rreg(8'h24, 9'h140);
      rreg(8'h26, 9'h100);
      done("straps low");
      results();
   end
endmodule
